// *** logic/bpx_cfg.svh ***
`ifndef BPX_CFG_SVH
`define BPX_CFG_SVH
// address modifier codes used by this link
`define BPX_AM_SINGLE 6'h09
`define BPX_AM_BLOCK 6'h0B
`define BPX_AM_RMW 6'h0A
// slave window: addr[31:6] must match, 64 bytes of storage
`define BPX_SLV_BASE 26'h0000010
`define BPX_MEM_BYTES 64
// interrupter level and status/id (status/id value is arbitrary)
`define BPX_IRQ_LEVEL 3'h3
`define BPX_STATUS_ID 8'h5A
`define BPX_IRQ_LEVELS 7
`define BPX_BLOCK_MAX_BYTES 256
// bus timer limit, longest wait rounds down
`define BPX_CLK_MHZ 100
`define BPX_BT_TIME_NS 1000
`define BPX_BT_CYCLES ((`BPX_BT_TIME_NS * `BPX_CLK_MHZ) / 1000)
// address-only hold, in cycles
`define BPX_AO_HOLD 3'h2
`define BPX_FIFO_DEPTH 16
`endif

// *** logic/bpx_pkg.sv ***
package bpx_pkg;
`include "bpx_cfg.svh"
  typedef enum logic [2:0] {
    BPX_K_READ = 3'h0,
    BPX_K_WRITE = 3'h1,
    BPX_K_BREAD = 3'h2,
    BPX_K_BWRITE = 3'h3,
    BPX_K_RMW = 3'h4,
    BPX_K_AONLY = 3'h5,
    BPX_K_IACK = 3'h6
  } bpx_kind_type;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_IGNORE = 5'h02,
    S_WAIT = 5'h04,
    S_DRIVE = 5'h08,
    S_ACK = 5'h10
  } bpx_slv_state_type;
  typedef enum logic [6:0] {
    M_IDLE = 7'h01,
    M_REQ = 7'h02,
    M_ADDR = 7'h04,
    M_NEXT = 7'h08,
    M_WDATA = 7'h10,
    M_STROBE = 7'h20,
    M_REL = 7'h40
  } bpx_mst_state_type;
  // size code 0..3 means 1..4 bytes
  function automatic logic [2:0] bpx_nbytes(input logic [1:0] size);
    return 3'(size) + 3'h1;
  endfunction
endpackage

// *** logic/bpx_if.sv ***
`timescale 1ns/10ps
interface bpx_if;
  logic [31:0] addr;
  logic [5:0] am;
  logic [1:0] size;
  logic as_n;
  logic ds_n;
  logic write_n;
  logic iack_n;
  logic br_n;
  logic bg_n;
  logic dtack_n;
  logic berr_n;
  logic [7:1] irq_n;
  logic [31:0] m_data;
  logic m_data_oe;
  logic [31:0] s_data;
  logic s_data_oe;
  logic [31:0] data;
  // shared data lines, idle level high
  assign data = m_data_oe ? m_data : (s_data_oe ? s_data : 32'hFFFFFFFF);
  modport mst (output addr, am, size, as_n, ds_n, write_n, iack_n, br_n, m_data, m_data_oe,
               input bg_n, dtack_n, berr_n, irq_n, data);
  modport slv (input addr, am, size, as_n, ds_n, write_n, iack_n, br_n, data,
               output bg_n, dtack_n, berr_n, irq_n, s_data, s_data_oe);
endinterface

// *** logic/bpx_fifo.sv ***
`timescale 1ns/10ps
module bpx_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [WIDTH-1:0] mem_next [0:DEPTH-1];
  logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
  logic push, pop;

  // full when pointers differ only in the wrap bit
  assign o_in_ready = (wp_reg ^ rp_reg) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wp_reg != rp_reg;
  assign o_out_data = mem_reg[rp_reg[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // pointer and storage update
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (push) begin
      mem_next[wp_reg[AW-1:0]] = i_in_data;
      wp_next = wp_reg + 1'b1;
    end
    if (pop) begin
      rp_next = rp_reg + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      mem_reg <= mem_next;
    end
  end
endmodule

// *** logic/bpx_master.sv ***
`timescale 1ns/10ps
`include "bpx_cfg.svh"
module bpx_master import bpx_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  bpx_if.mst bus,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire bpx_kind_type i_cmd_kind,
  input wire logic [31:0] i_cmd_addr,
  input wire logic [1:0] i_cmd_size,
  input wire logic [7:0] i_cmd_beats,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [31:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [31:0] o_rd_data,
  output logic o_done,
  output logic o_err,
  output logic [2:0] o_irq_level
);
  bpx_mst_state_type st_reg, st_next;
  bpx_kind_type kind_reg, kind_next;
  logic [7:0] beats_reg, beats_next;
  logic [2:0] hold_reg, hold_next, lvl_reg, lvl_next;
  logic phase_reg, phase_next, err_reg, err_next, done_reg, done_next;
  logic crdy_reg, crdy_next, wrdy_reg, wrdy_next;
  logic [31:0] addr_reg, addr_next, wd_reg, wd_next;
  logic [5:0] am_reg, am_next;
  logic [1:0] size_reg, size_next;
  logic as_n_reg, as_n_next, ds_n_reg, ds_n_next, wr_n_reg, wr_n_next;
  logic iack_n_reg, iack_n_next, br_n_reg, br_n_next, oe_reg, oe_next;
  logic writing, push, room;

  assign bus.addr = addr_reg;
  assign bus.am = am_reg;
  assign bus.size = size_reg;
  assign bus.as_n = as_n_reg;
  assign bus.ds_n = ds_n_reg;
  assign bus.write_n = wr_n_reg;
  assign bus.iack_n = iack_n_reg;
  assign bus.br_n = br_n_reg;
  assign bus.m_data = wd_reg;
  assign bus.m_data_oe = oe_reg;
  assign o_cmd_ready = crdy_reg;
  assign o_wr_ready = wrdy_reg;
  assign o_done = done_reg;
  assign o_err = err_reg;
  assign o_irq_level = lvl_reg;
  // rmw writes in its second phase
  assign writing = kind_reg == BPX_K_WRITE || kind_reg == BPX_K_BWRITE || (kind_reg == BPX_K_RMW && phase_reg);
  assign push = st_reg == M_STROBE && !writing && !bus.dtack_n;

  // read data and status/id toward the user, stalls reads when full
  bpx_fifo #(.WIDTH(32), .DEPTH(`BPX_FIFO_DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(push),
    .o_in_ready(room),
    .i_in_data(bus.data),
    .o_out_valid(o_rd_valid),
    .i_out_ready(i_rd_ready),
    .o_out_data(o_rd_data)
  );

  // cycle sequencer
  always_comb begin
    st_next = st_reg;
    kind_next = kind_reg;
    beats_next = beats_reg;
    hold_next = hold_reg;
    phase_next = phase_reg;
    err_next = err_reg;
    done_next = 1'b0;
    addr_next = addr_reg;
    am_next = am_reg;
    size_next = size_reg;
    wd_next = wd_reg;
    as_n_next = as_n_reg;
    ds_n_next = ds_n_reg;
    wr_n_next = wr_n_reg;
    iack_n_next = iack_n_reg;
    br_n_next = br_n_reg;
    oe_next = oe_reg;
    lvl_next = 3'h0;
    // highest pending level wins
    for (int i = 1; i <= `BPX_IRQ_LEVELS; i++) begin
      if (!bus.irq_n[i]) begin
        lvl_next = 3'(i);
      end
    end
    unique case (st_reg)
      M_IDLE: begin
        if (i_cmd_valid && crdy_reg) begin
          kind_next = i_cmd_kind;
          beats_next = i_cmd_beats;
          size_next = i_cmd_size;
          addr_next = i_cmd_addr;
          phase_next = 1'b0;
          err_next = 1'b0;
          br_n_next = 1'b0; // ask for the bus first
          st_next = M_REQ;
        end
      end
      M_REQ: begin
        // address (except for iack) and size already loaded, modifier, direction and strobes wait for the grant; iack only with a pending request
        if (!bus.bg_n && (kind_reg != BPX_K_IACK || lvl_reg != 3'h0)) begin
          if (kind_reg == BPX_K_IACK) begin
            addr_next = {28'h0, lvl_reg, 1'b0};
          end
          am_next = kind_reg == BPX_K_RMW ? `BPX_AM_RMW :
                    (kind_reg == BPX_K_BREAD || kind_reg == BPX_K_BWRITE) ? `BPX_AM_BLOCK : `BPX_AM_SINGLE;
          wr_n_next = !writing;
          iack_n_next = kind_reg != BPX_K_IACK;
          as_n_next = 1'b0; // one broadcast per cycle
          hold_next = 3'h0;
          st_next = M_ADDR;
        end
      end
      M_ADDR: begin
        if (kind_reg != BPX_K_AONLY) begin
          st_next = M_NEXT;
        end else if (hold_reg == `BPX_AO_HOLD) begin
          as_n_next = 1'b1; // ends by itself, no data, no wait for ack
          br_n_next = 1'b1;
          done_next = 1'b1;
          st_next = M_IDLE;
        end else begin
          hold_next = hold_reg + 3'h1;
        end
      end
      M_NEXT: begin
        if (writing) begin
          st_next = M_WDATA;
        end else if (room) begin
          ds_n_next = 1'b0;
          st_next = M_STROBE;
        end
      end
      M_WDATA: begin
        if (i_wr_valid && wrdy_reg) begin
          wd_next = i_wr_data; // data with the strobe
          oe_next = 1'b1;
          ds_n_next = 1'b0;
          st_next = M_STROBE;
        end
      end
      M_STROBE: begin
        if (!bus.dtack_n || !bus.berr_n) begin
          err_next = !bus.berr_n;
          ds_n_next = 1'b1;
          oe_next = 1'b0;
          st_next = M_REL;
        end
      end
      M_REL: begin
        if (bus.dtack_n && bus.berr_n) begin
          if (!err_reg && kind_reg == BPX_K_RMW && !phase_reg) begin
            phase_next = 1'b1; // address strobe held low across both halves
            wr_n_next = 1'b0;
            st_next = M_NEXT;
          end else if (!err_reg && beats_reg != 8'h00 &&
                       (kind_reg == BPX_K_BREAD || kind_reg == BPX_K_BWRITE)) begin
            beats_next = beats_reg - 8'h01; // bus kept until last beat
            st_next = M_NEXT;
          end else begin
            as_n_next = 1'b1; // master closes the cycle
            br_n_next = 1'b1;
            iack_n_next = 1'b1;
            wr_n_next = 1'b1;
            done_next = 1'b1;
            st_next = M_IDLE;
          end
        end
      end
    endcase
    crdy_next = st_next == M_IDLE;
    wrdy_next = st_next == M_WDATA && !(st_reg == M_WDATA && i_wr_valid && wrdy_reg);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= M_IDLE;
      kind_reg <= BPX_K_READ;
      beats_reg <= 8'h00;
      hold_reg <= 3'h0;
      phase_reg <= 1'b0;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
      crdy_reg <= 1'b0;
      wrdy_reg <= 1'b0;
      addr_reg <= 32'h00000000;
      wd_reg <= 32'h00000000;
      am_reg <= 6'h00;
      size_reg <= 2'h0;
      as_n_reg <= 1'b1;
      ds_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      iack_n_reg <= 1'b1;
      br_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      lvl_reg <= 3'h0;
    end else begin
      st_reg <= st_next;
      kind_reg <= kind_next;
      beats_reg <= beats_next;
      hold_reg <= hold_next;
      phase_reg <= phase_next;
      err_reg <= err_next;
      done_reg <= done_next;
      crdy_reg <= crdy_next;
      wrdy_reg <= wrdy_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      am_reg <= am_next;
      size_reg <= size_next;
      as_n_reg <= as_n_next;
      ds_n_reg <= ds_n_next;
      wr_n_reg <= wr_n_next;
      iack_n_reg <= iack_n_next;
      br_n_reg <= br_n_next;
      oe_reg <= oe_next;
      lvl_reg <= lvl_next;
    end
  end
endmodule

// *** logic/bpx_slave.sv ***
// Notes on behaviour
// - single read moves one to four bytes
// - latch address and modifier, decide selection
// - selected read: fetch, drive data, then acknowledge
// - single write carries data with the data strobe, after the address
// - selected write: store and acknowledge on the same edge
// - master ends single cycles after acknowledge
// - block read up to 256 bytes; the master allows 256 beats of up to four bytes
// - block write up to 256 bytes; the master allows 256 beats of up to four bytes
// - master holds bus for whole block
// - block address broadcast only once
// - block read advances slave address each beat
// - block write advances slave address each beat
// - read-modify-write is one indivisible access
// - address-only cycle carries no data
// - slave never acknowledges address-only cycles
// - master ends address-only cycle unacknowledged
// - interrupt acknowledge reads status/id from interrupter
// - handler acknowledges only pending request, owning bus
// - one bus owner at a time
// - at most seven interrupt priority levels
// - bus timer ends overlong transfers with error
// - suffixed lines are asserted when low
`timescale 1ns/10ps
`include "bpx_cfg.svh"
module bpx_slave import bpx_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  bpx_if.slv bus,
  input wire logic i_irq_req,
  output logic o_irq_pending,
  output logic o_wr_pulse,
  output logic o_bt_expired
);
  bpx_slv_state_type st_reg, st_next;
  logic [31:0] addr_reg, addr_next;
  logic [5:0] am_reg, am_next;
  logic iack_reg, iack_next;
  logic [7:0] mem_reg [0:`BPX_MEM_BYTES-1];
  logic [7:0] mem_next [0:`BPX_MEM_BYTES-1];
  logic [31:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic dtack_n_reg, dtack_n_next;
  logic berr_n_reg, berr_n_next;
  logic bg_n_reg, bg_n_next;
  logic irq_reg, irq_next;
  logic wrp_reg, wrp_next;
  logic bte_reg, bte_next;
  logic [7:0] bt_cnt_reg, bt_cnt_next;
  logic [2:0] nb;
  logic [5:0] ix;
  logic hit;

  // every bus line leaves a flip-flop, active-low lines idle high
  assign bus.dtack_n = dtack_n_reg;
  assign bus.berr_n = berr_n_reg;
  assign bus.bg_n = bg_n_reg;
  assign bus.irq_n = ~(7'(irq_reg) << (`BPX_IRQ_LEVEL - 3'h1));
  assign bus.s_data = dout_reg;
  assign bus.s_data_oe = doe_reg;
  assign o_irq_pending = irq_reg;
  assign o_wr_pulse = wrp_reg;
  assign o_bt_expired = bte_reg;
  assign nb = bpx_nbytes(bus.size);

  // window and modifier decode
  assign hit = (bus.am == `BPX_AM_SINGLE || bus.am == `BPX_AM_BLOCK || bus.am == `BPX_AM_RMW) &&
               bus.addr[31:6] == `BPX_SLV_BASE;

  // arbiter, bus timer, interrupter and slave sequencer
  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    am_next = am_reg;
    iack_next = iack_reg;
    for (int i = 0; i < `BPX_MEM_BYTES; i++) begin
      mem_next[i] = mem_reg[i];
    end
    ix = 6'h00;
    dout_next = dout_reg;
    doe_next = doe_reg;
    dtack_n_next = dtack_n_reg;
    berr_n_next = berr_n_reg;
    bg_n_next = bg_n_reg;
    bt_cnt_next = bt_cnt_reg;
    wrp_next = 1'b0;
    bte_next = 1'b0;
    // a new request wins over the clear on acknowledge
    irq_next = irq_reg | i_irq_req;

    // grant only between cycles, so ownership never overlaps
    if (bus.as_n) begin
      if (bg_n_reg && !bus.br_n) begin
        bg_n_next = 1'b0;
      end else if (!bg_n_reg && bus.br_n) begin
        bg_n_next = 1'b1;
      end
    end

    // time each strobe and raise bus error when nobody answers
    if (bus.ds_n) begin
      bt_cnt_next = 8'h00;
      berr_n_next = 1'b1;
    end else if (dtack_n_reg && berr_n_reg) begin
      if (bt_cnt_reg == 8'(`BPX_BT_CYCLES - 1)) begin
        berr_n_next = 1'b0;
        bte_next = 1'b1;
      end else begin
        bt_cnt_next = bt_cnt_reg + 8'h01;
      end
    end

    unique case (st_reg)
      S_IDLE: begin
        if (!bus.as_n) begin
          addr_next = bus.addr; // capture on the address broadcast
          am_next = bus.am;
          iack_next = !bus.iack_n;
          if (!bus.iack_n) begin
            // answer only our own pending level
            st_next = (irq_reg && bus.addr[3:1] == `BPX_IRQ_LEVEL) ? S_WAIT : S_IGNORE;
          end else begin
            st_next = hit ? S_WAIT : S_IGNORE;
          end
        end
      end
      S_IGNORE: begin
        // no data, no acknowledge until the strobe drops
        if (bus.as_n) begin
          st_next = S_IDLE;
        end
      end
      S_WAIT: begin
        // address-only cycles never see a data strobe, so stay silent
        if (bus.as_n) begin
          st_next = S_IDLE;
        end else if (!bus.ds_n && berr_n_reg) begin
          if (iack_reg) begin
            dout_next = {24'h000000, `BPX_STATUS_ID};
            doe_next = 1'b1;
            st_next = S_DRIVE;
          end else if (!bus.write_n) begin
            // store and acknowledge together on the next edge
            for (int k = 0; k < 4; k++) begin
              ix = addr_reg[5:0] + 6'(k);
              if (3'(k) < nb) begin
                mem_next[ix] = bus.data[8*k +: 8];
              end
            end
            wrp_next = 1'b1;
            dtack_n_next = 1'b0;
            st_next = S_ACK;
          end else begin
            // fetch and drive, acknowledge one cycle later
            dout_next = 32'hFFFFFFFF;
            for (int k = 0; k < 4; k++) begin
              ix = addr_reg[5:0] + 6'(k);
              if (3'(k) < nb) begin
                dout_next[8*k +: 8] = mem_reg[ix];
              end
            end
            doe_next = 1'b1;
            st_next = S_DRIVE;
          end
          // next beat from the next higher location
          if (am_reg == `BPX_AM_BLOCK && !iack_reg) begin
            addr_next = addr_reg + 32'(nb);
          end
          // rmw keeps one address for both halves
        end
      end
      S_DRIVE: begin
        dtack_n_next = 1'b0;
        st_next = S_ACK;
      end
      S_ACK: begin
        // hold until the master lets the data strobe go
        if (bus.ds_n) begin
          dtack_n_next = 1'b1;
          doe_next = 1'b0;
          if (iack_reg) begin
            irq_next = i_irq_req;
          end
          st_next = S_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= S_IDLE;
      addr_reg <= 32'h00000000;
      am_reg <= 6'h00;
      iack_reg <= 1'b0;
      for (int i = 0; i < `BPX_MEM_BYTES; i++) begin
        mem_reg[i] <= 8'h00;
      end
      dout_reg <= 32'h00000000;
      doe_reg <= 1'b0;
      dtack_n_reg <= 1'b1;
      berr_n_reg <= 1'b1;
      bg_n_reg <= 1'b1;
      irq_reg <= 1'b0;
      wrp_reg <= 1'b0;
      bte_reg <= 1'b0;
      bt_cnt_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      am_reg <= am_next;
      iack_reg <= iack_next;
      mem_reg <= mem_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      dtack_n_reg <= dtack_n_next;
      berr_n_reg <= berr_n_next;
      bg_n_reg <= bg_n_next;
      irq_reg <= irq_next;
      wrp_reg <= wrp_next;
      bte_reg <= bte_next;
      bt_cnt_reg <= bt_cnt_next;
    end
  end
endmodule

// *** tb/bpx_properties.sv ***
`timescale 1ns/10ps
`include "bpx_cfg.svh"
module bpx_properties (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [31:0] addr,
  input wire logic [5:0] am,
  input wire logic as_n,
  input wire logic ds_n,
  input wire logic write_n,
  input wire logic iack_n,
  input wire logic br_n,
  input wire logic bg_n,
  input wire logic dtack_n,
  input wire logic berr_n,
  input wire logic [7:1] irq_n,
  input wire logic m_data_oe,
  input wire logic s_data_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] bt_cnt_reg;
  logic [7:0] bt_cnt_next;
  logic sel;
  // cycles a strobe waits unanswered
  always_comb begin
    bt_cnt_next = (!ds_n && dtack_n && berr_n) ? bt_cnt_reg + 8'h01 : 8'h00;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bt_cnt_reg <= 8'h00;
    end else begin
      bt_cnt_reg <= bt_cnt_next;
    end
  end
  // slave window hit
  assign sel = iack_n && (addr[31:6] == `BPX_SLV_BASE);
  sequence s_rd_strobe;
    $fell(ds_n) && write_n && sel;
  endsequence
  sequence s_wr_strobe;
    $fell(ds_n) && !write_n && sel;
  endsequence
  AST_READ_ACK: assert property (s_rd_strobe |-> ##[1:3] (!dtack_n && s_data_oe))
    else $error("read beat not answered with data");
  AST_WRITE_ACK: assert property (s_wr_strobe |-> ##[1:2] (!dtack_n && !s_data_oe))
    else $error("write beat not acknowledged");
  AST_ACK_RELEASE: assert property ($rose(ds_n) |-> ##[1:2] dtack_n)
    else $error("acknowledge held after strobe end");
  AST_ACK_NEEDS_STROBE: assert property ($fell(dtack_n) |-> !$past(ds_n))
    else $error("acknowledge without data strobe");
  AST_UNSELECTED_SILENT: assert property (!as_n && iack_n && !sel |-> dtack_n && !s_data_oe)
    else $error("unselected slave answered");
  AST_ADDR_ONCE: assert property (!as_n && !$past(as_n) |-> $stable(addr) && $stable(am))
    else $error("address changed inside cycle");
  AST_GRANT_ORDER: assert property ($fell(bg_n) |-> !$past(br_n) && $past(as_n))
    else $error("grant without request or while bus busy");
  AST_ONE_DRIVER: assert property (!(m_data_oe && s_data_oe))
    else $error("both ends drive data");
  AST_IRQ_LINES: assert property (irq_n[7:4] == 4'hF && irq_n[2:1] == 2'h3)
    else $error("interrupt on wrong level");
  AST_BT_LIMIT: assert property (bt_cnt_reg <= 8'(`BPX_BT_CYCLES))
    else $error("bus timer too late");
  AST_BT_CAUSE: assert property ($fell(berr_n) |-> !ds_n && bt_cnt_reg == 8'(`BPX_BT_CYCLES))
    else $error("bus error without long wait");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
`include "bpx_cfg.svh"
module tb;
  import bpx_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  bpx_kind_type cmd_kind = BPX_K_READ;
  logic [31:0] cmd_addr = 32'h0;
  logic [1:0] cmd_size = 2'h0;
  logic [7:0] cmd_beats = 8'h00;
  logic wr_valid = 1'b0;
  logic wr_ready;
  logic [31:0] wr_data = 32'h0;
  logic rd_valid;
  logic rd_ready = 1'b0;
  logic [31:0] rd_data;
  logic done, err, irq_req = 1'b0, irq_pending, wr_pulse, bt_expired;
  logic [2:0] irq_level;
  logic [7:0] mem [64];
  logic [31:0] exp_rd[$], wq[$];
  logic exp_err[$];
  int fail_count = 0, samples_checked = 0, dones = 0, bts = 0, wrs = 0, exp_wrs = 0, hold = 0;
  bpx_if bus_if ();
  bpx_master u_bpx_master (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .bus(bus_if), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(cmd_ready), .i_cmd_kind(cmd_kind), .i_cmd_addr(cmd_addr), .i_cmd_size(cmd_size),
    .i_cmd_beats(cmd_beats), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .i_wr_data(wr_data),
    .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_data(rd_data), .o_done(done), .o_err(err),
    .o_irq_level(irq_level));
  bpx_slave u_bpx_slave (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .bus(bus_if), .i_irq_req(irq_req),
    .o_irq_pending(irq_pending), .o_wr_pulse(wr_pulse), .o_bt_expired(bt_expired));
  bpx_properties u_bpx_properties (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .addr(bus_if.addr),
    .am(bus_if.am), .as_n(bus_if.as_n), .ds_n(bus_if.ds_n), .write_n(bus_if.write_n),
    .iack_n(bus_if.iack_n), .br_n(bus_if.br_n), .bg_n(bus_if.bg_n), .dtack_n(bus_if.dtack_n),
    .berr_n(bus_if.berr_n), .irq_n(bus_if.irq_n), .m_data_oe(bus_if.m_data_oe),
    .s_data_oe(bus_if.s_data_oe));
  // clock
  always #5 i_sys_clk = ~i_sys_clk;
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_data({31'h0, got}, {31'h0, exp});
  endtask
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(inout int n, input int lim);
    @(posedge i_sys_clk);
    #1;
    n++;
    if (n > lim) begin
      chk_data(32'(n), 32'(lim));
      end_sim();
    end
  endtask
  // expected beat: lanes above size read as ones
  function automatic logic [31:0] rd_exp(input logic [5:0] a, input logic [1:0] s);
    logic [31:0] v;
    v = 32'hFFFFFFFF;
    for (int k = 0; k <= int'(s); k++) begin
      v[8*k+:8] = mem[6'(a + 6'(k))];
    end
    return v;
  endfunction
  // notes expectations, then issues one command and waits for its end
  task automatic run(input bpx_kind_type k, input logic [31:0] a, input logic [1:0] s,
                     input logic [7:0] b, input logic e);
    logic [31:0] d;
    int n;
    int t;
    t = dones + 1;
    for (int i = 0; i <= int'(b); i++) begin
      d = $urandom;
      if (k == BPX_K_READ || k == BPX_K_BREAD || k == BPX_K_RMW) begin
        exp_rd.push_back(rd_exp(a[5:0], s));
      end
      if (k == BPX_K_WRITE || k == BPX_K_BWRITE || k == BPX_K_RMW) begin
        wq.push_back(d);
        exp_wrs += e ? 0 : 1;
        for (int j = 0; j <= int'(s) && !e; j++) begin
          mem[6'(a[5:0] + 6'(j))] = d[8*j+:8];
        end
      end
      a = a + 32'(s) + 32'h1;
    end
    if (k == BPX_K_IACK) begin
      exp_rd.push_back({24'h000000, `BPX_STATUS_ID});
    end
    exp_err.push_back(e);
    n = 0;
    while (cmd_ready !== 1'b1) begin
      tick(n, 50);
    end
    // fields one by one, the kind keeps its enum type
    cmd_kind = k;
    cmd_addr = a - (32'(b) + 32'h1) * (32'(s) + 32'h1);
    cmd_size = s;
    cmd_beats = b;
    cmd_valid = 1'b1;
    @(posedge i_sys_clk);
    #1;
    cmd_valid = 1'b0;
    while (dones != t) begin
      tick(n, 4000);
    end
  endtask
  // write stream feed and read side stalls
  always @(posedge i_sys_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      void'(wq.pop_front());
    end
    #1;
    wr_valid = wq.size() != 0;
    wr_data = wq.size() != 0 ? wq[0] : 32'h0;
    rd_ready = hold == 0 && $urandom_range(0, 3) != 0;
    hold = hold > 0 ? hold - 1 : 0;
  end
  // result watcher
  always @(posedge i_sys_clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (exp_rd.size() != 0) begin
        chk_data(rd_data, exp_rd.pop_front());
      end else begin
        chk_flag(1'b1, 1'b0);
      end
    end
    if (done === 1'b1) begin
      dones++;
      if (exp_err.size() != 0) begin
        chk_flag(err, exp_err.pop_front());
      end else begin
        chk_flag(1'b1, 1'b0);
      end
    end
    bts += bt_expired === 1'b1 ? 1 : 0;
    wrs += wr_pulse === 1'b1 ? 1 : 0;
  end
  // main sequence
  initial begin
    int n;
    void'($urandom(45));
    repeat (4) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    run(BPX_K_BWRITE, 32'h400, 2'h3, 8'h0F, 1'b0);
    run(BPX_K_BWRITE, 32'h410, 2'h0, 8'h00, 1'b0);
    for (int i = 0; i < 16; i++) begin
      run(i[0] ? BPX_K_WRITE : BPX_K_READ, 32'h400 + 32'($urandom_range(0, 63)), 2'($urandom_range(0, 3)),
          8'h00, 1'b0);
    end
    run(BPX_K_BREAD, 32'h400, 2'h1, 8'h1F, 1'b0);
    hold = 150;
    run(BPX_K_BREAD, 32'h420, 2'h0, 8'h13, 1'b0);
    run(BPX_K_BWRITE, 32'h408, 2'h1, 8'h03, 1'b0);
    run(BPX_K_RMW, 32'h40C, 2'h3, 8'h00, 1'b0);
    run(BPX_K_READ, 32'h40C, 2'h3, 8'h00, 1'b0);
    run(BPX_K_AONLY, 32'h404, 2'h3, 8'h00, 1'b0);
    irq_req = 1'b1;
    @(posedge i_sys_clk);
    #1;
    irq_req = 1'b0;
    n = 0;
    while (irq_level !== `BPX_IRQ_LEVEL) begin
      tick(n, 50);
    end
    chk_flag(irq_pending, 1'b1);
    run(BPX_K_IACK, 32'h0, 2'h0, 8'h00, 1'b0);
    chk_flag(irq_pending, 1'b0);
    run(BPX_K_WRITE, 32'h0, 2'h3, 8'h00, 1'b1);
    chk_data(32'(bts), 32'h1);
    chk_data(32'(wrs), 32'(exp_wrs));
    end_sim();
  end
endmodule
